// [hw/wavegen_pkg.sv]
package wavegen_pkg;

  // ------------------------------------------------------------------
  // Register byte addresses (AXI4-Lite, one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CLOCK_SOURCE_SELECT = 4'h0; // Clock pick
  localparam logic [3:0] ADDR_DATA_INPUT_SELECT = 4'h4; // Source pick
  localparam logic [3:0] ADDR_OUTPUT_STEERING_CONTROL = 4'h8; // Steering
  localparam logic [3:0] ADDR_WAVE_CONTROL = 4'hC; // Mode and polarity

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CLOCK_PICK_BIT = 0; // Clock select bit
  localparam int FORCE_LSB = 4; // Override levels sit in 7:4
  localparam int ROUTE_LSB = 0; // Steering enables sit in 3:0
  localparam int MODE_LSB = 0; // Mode field 2:0 of control word
  localparam int INVERT_LSB = 8; // Polarity bits 11:8 of control word
  localparam int INPUT_BIT = 16; // Read-only data input level
  localparam logic [7:0] RESET_BYTE = 8'h00; // Every field clears on reset

  // ------------------------------------------------------------------
  // Mode field encodings
  // ------------------------------------------------------------------
  localparam logic [2:0] MODE_ASYNC_STEER = 3'h0; // Steering at once
  localparam logic [2:0] MODE_SYNC_STEER = 3'h1; // Steering at period edge

  // ------------------------------------------------------------------
  // Data source codes
  // ------------------------------------------------------------------
  localparam logic [3:0] SRC_PIN_SELECT = 4'h0;
  localparam logic [3:0] SRC_COMPARATOR_ONE = 4'h1;
  localparam logic [3:0] SRC_COMPARATOR_TWO = 4'h2;
  localparam logic [3:0] SRC_CAPTURE_ONE = 4'h3;
  localparam logic [3:0] SRC_CAPTURE_TWO = 4'h4;
  localparam logic [3:0] SRC_PULSE_FIVE = 4'h7;
  localparam logic [3:0] SRC_PULSE_SIX = 4'h8;
  localparam logic [3:0] SRC_NUMERIC_OSC = 4'h9;
  localparam logic [3:0] SRC_LOGIC_ONE = 4'hA;
  localparam logic [3:0] SRC_LOGIC_TWO = 4'hB;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [hw/steer_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Configuration handed from the register file to the steering logic
interface steer_cfg_if;
  logic [3:0] force_level; // Override levels D..A in 3:0
  logic [3:0] route_enable; // Steering enables D..A in 3:0
  logic [3:0] invert_out; // Polarity bits D..A in 3:0
  logic [2:0] mode; // Output mode
  logic data_in; // Selected data input level
  modport regs (output force_level, route_enable, invert_out, mode, input data_in);
  modport core (input force_level, route_enable, invert_out, mode, output data_in);
endinterface
`default_nettype wire

// [hw/source_mux.sv]
`timescale 1ns/1ps
`default_nettype none
// Picks the data input from the on-chip sources; reserved codes give 0
module source_mux
  import wavegen_pkg::*;
#(
  parameter bit HAS_COMPARATOR_TWO = 1'b1 // Larger device variant
) (
  input wire logic [3:0] pick_i,
  input wire logic [10:0] sources_i,
  output logic data_o
);
  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  // Sources order: 0 pin, 1..2 comparators, 3..4 capture, 5..6 pulse,
  // 7 numeric oscillator, 8..9 logic cells
  always_comb begin
    case (pick_i)
      SRC_PIN_SELECT: data_o = sources_i[0]; // R02
      SRC_COMPARATOR_ONE: data_o = sources_i[1];
      SRC_COMPARATOR_TWO: data_o = HAS_COMPARATOR_TWO ? sources_i[2] : 1'b0; // R03
      SRC_CAPTURE_ONE: data_o = sources_i[3];
      SRC_CAPTURE_TWO: data_o = sources_i[4];
      SRC_PULSE_FIVE: data_o = sources_i[5];
      SRC_PULSE_SIX: data_o = sources_i[6];
      SRC_NUMERIC_OSC: data_o = sources_i[7];
      SRC_LOGIC_ONE: data_o = sources_i[8];
      SRC_LOGIC_TWO: data_o = sources_i[9];
      default: data_o = 1'b0; // Reserved selections read low
    endcase
  end
endmodule
`default_nettype wire

// [hw/output_steer.sv]
`timescale 1ns/1ps
`default_nettype none
// Per-output steering with override, polarity and sync double-buffer
module output_steer
  import wavegen_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic period_edge_i,
  steer_cfg_if.core cfg,
  output logic [3:0] wave_o
);
  logic [3:0] live_route; // Enables in force on the outputs
  logic [3:0] next_live_route;
  logic [3:0] next_wave;
  logic steer_mode; // Mode is one of the steering modes

  // ------------------------------------------------------------------
  // Steering enable buffer
  // ------------------------------------------------------------------
  always_comb begin
    steer_mode = (cfg.mode == MODE_ASYNC_STEER) || (cfg.mode == MODE_SYNC_STEER); // R09
    if (cfg.mode == MODE_SYNC_STEER) begin
      // Only load at a period boundary to avoid glitching mid-cycle
      next_live_route = period_edge_i ? cfg.route_enable : live_route; // R11
    end else begin
      next_live_route = cfg.route_enable;
    end
  end

  // ------------------------------------------------------------------
  // Per-output drive
  // ------------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_out
    always_comb begin
      if (!steer_mode) begin
        next_wave[i] = 1'b0; // Other modes not served here; hold low
      end else if (live_route[i]) begin
        next_wave[i] = cfg.data_in ^ cfg.invert_out[i]; // R05 R10
      end else begin
        next_wave[i] = cfg.force_level[i]; // R05
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      live_route <= 4'h0; // R08
      wave_o <= 4'h0; // R08
    end else if (enable_i) begin
      live_route <= next_live_route;
      wave_o <= next_wave;
    end
  end
endmodule
`default_nettype wire

// [hw/waveform_gen_input_steering.sv]
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01: Clock select bit: system or fast oscillator
// R02: Four-bit code routes waveform data input
// R03: Second comparator code reserved on small variant
// R04: Steering register: overrides 7:4, enables 3:0
// R05: Enable clear forces override; set steers data
// R06: Clock select bits 7:1 read zero
// R07: Data select bits 7:4 read zero
// R08: All fields reset to zero
// R09: Steering applies only in steering modes
// R10: Polarity bit inverts steered output
// R11: Sync mode loads enables at period edge
module waveform_gen_input_steering
  import wavegen_pkg::*;
#(
  parameter bit HAS_COMPARATOR_TWO = 1'b1, // Larger device variant
  parameter int ADDR_W = 4 // AXI address width
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Data sources
  input wire logic pin_select_input_i,
  input wire logic comparator_one_result_i,
  input wire logic comparator_two_result_i,
  input wire logic capture_compare_one_i,
  input wire logic capture_compare_two_i,
  input wire logic pulse_unit_five_i,
  input wire logic pulse_unit_six_i,
  input wire logic numeric_oscillator_one_i,
  input wire logic logic_cell_one_i,
  input wire logic logic_cell_two_i,
  input wire logic period_edge_i, // Waveform period boundary pulse
  // Outputs
  output logic clock_pick_o, // 1 selects internal fast oscillator
  output logic wave_output_a_o,
  output logic wave_output_b_o,
  output logic wave_output_c_o,
  output logic wave_output_d_o
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (ADDR_W < 4) begin : g_bad_addr
    $error("ADDR_W must be at least 4");
  end

  steer_cfg_if cfg ();

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic clock_pick; // Clock select bit
  logic [3:0] source_pick; // Data source code
  logic [7:0] steering; // Overrides and enables
  logic [2:0] mode; // Output mode
  logic [3:0] invert; // Polarity D..A
  logic clock_pick_q; // Registered clock select output
  logic next_clock_pick;
  logic [3:0] next_source_pick;
  logic [7:0] next_steering;
  logic [2:0] next_mode;
  logic [3:0] next_invert;

  // Bus state
  logic aw_held; // Write address captured
  logic w_held; // Write data captured
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_route_enable_b;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_route_enable_b;
  logic [1:0] next_bresp, next_rresp;
  logic do_write; // Both halves present and response channel free
  logic [3:0] wave;
  logic [31:0] read_word;

  // ------------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------------
  // Address and data are taken in either order; the write commits
  // once both are held and any prior response has been accepted.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_route_enable_b = w_route_enable_b;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_clock_pick = clock_pick;
    next_source_pick = source_pick;
    next_steering = steering;
    next_mode = mode;
    next_invert = invert;
    if (s_axi_awvalid_i && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_route_enable_b = s_axi_wstrb_i;
    end
    if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    do_write = aw_held && w_held && !bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr[3:0])
        ADDR_CLOCK_SOURCE_SELECT: begin
          if (w_route_enable_b[0]) begin
            next_clock_pick = w_data[CLOCK_PICK_BIT]; // R01
          end
        end
        ADDR_DATA_INPUT_SELECT: begin
          if (w_route_enable_b[0]) begin
            next_source_pick = w_data[3:0]; // R02
          end
        end
        ADDR_OUTPUT_STEERING_CONTROL: begin
          if (w_route_enable_b[0]) begin
            next_steering = w_data[7:0]; // R04
          end
        end
        ADDR_WAVE_CONTROL: begin
          if (w_route_enable_b[0]) begin
            next_mode = w_data[MODE_LSB +: 3];
          end
          if (w_route_enable_b[1]) begin
            next_invert = w_data[INVERT_LSB +: 4]; // R10
          end
        end
        default: begin
          next_bresp = RESP_SLVERR; // Unmapped address
        end
      endcase
      if ((aw_addr >> 4) != '0) begin
        next_bresp = RESP_SLVERR;
        next_clock_pick = clock_pick;
        next_source_pick = source_pick;
        next_steering = steering;
        next_mode = mode;
        next_invert = invert;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    read_word = 32'h0000_0000;
    next_rresp = RESP_OKAY;
    case (s_axi_araddr_i[3:0])
      ADDR_CLOCK_SOURCE_SELECT: read_word = {31'h0000_0000, clock_pick}; // R06
      ADDR_DATA_INPUT_SELECT: read_word = {28'h000_0000, source_pick}; // R07
      ADDR_OUTPUT_STEERING_CONTROL: read_word = {24'h00_0000, steering};
      ADDR_WAVE_CONTROL: begin
        read_word[MODE_LSB +: 3] = mode;
        read_word[INVERT_LSB +: 4] = invert;
        read_word[INPUT_BIT] = cfg.data_in; // Live data input level
      end
      default: next_rresp = RESP_SLVERR;
    endcase
    if ((s_axi_araddr_i >> 4) != '0) begin
      read_word = 32'h0000_0000;
      next_rresp = RESP_SLVERR;
    end
    next_rvalid = rvalid;
    next_rdata = rdata;
    if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && arready) begin
      next_rvalid = 1'b1;
      next_rdata = read_word;
    end else begin
      next_rresp = rresp;
    end
  end

  // ------------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clock_pick <= RESET_BYTE[0]; // R08
      source_pick <= RESET_BYTE[3:0]; // R08
      steering <= RESET_BYTE; // R08
      mode <= MODE_ASYNC_STEER;
      invert <= RESET_BYTE[3:0];
      clock_pick_q <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_route_enable_b <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      awready <= 1'b1;
      wready <= 1'b1;
      arready <= 1'b1;
    end else if (clk_en_i) begin
      clock_pick <= next_clock_pick;
      source_pick <= next_source_pick;
      steering <= next_steering;
      mode <= next_mode;
      invert <= next_invert;
      clock_pick_q <= next_clock_pick; // R01
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_route_enable_b <= next_w_route_enable_b;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      awready <= !next_aw_held; // Ready while the slot is empty
      wready <= !next_w_held;
      arready <= !next_rvalid;
    end
  end

  // ------------------------------------------------------------------
  // Configuration to the steering core
  // ------------------------------------------------------------------
  assign cfg.force_level = steering[FORCE_LSB +: 4]; // R04
  assign cfg.route_enable = steering[ROUTE_LSB +: 4]; // R04
  assign cfg.invert_out = invert;
  assign cfg.mode = mode;

  source_mux #(
    .HAS_COMPARATOR_TWO(HAS_COMPARATOR_TWO)
  ) u_mux (
    .pick_i(source_pick),
    .sources_i({1'b0, logic_cell_two_i, logic_cell_one_i, numeric_oscillator_one_i,
      pulse_unit_six_i, pulse_unit_five_i, capture_compare_two_i, capture_compare_one_i,
      comparator_two_result_i, comparator_one_result_i, pin_select_input_i}),
    .data_o(cfg.data_in)
  );

  output_steer u_steer (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .enable_i(clk_en_i),
    .period_edge_i(period_edge_i),
    .cfg(cfg),
    .wave_o(wave)
  );

  // ------------------------------------------------------------------
  // Outputs, all straight from flops
  // ------------------------------------------------------------------
  assign s_axi_awready_o = awready;
  assign s_axi_wready_o = wready;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = arready;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rresp_o = rresp;
  assign s_axi_rdata_o = rdata;
  assign clock_pick_o = clock_pick_q;
  assign wave_output_a_o = wave[0];
  assign wave_output_b_o = wave[1];
  assign wave_output_c_o = wave[2];
  assign wave_output_d_o = wave[3];

endmodule
`default_nettype wire

// [tb/wave_sources.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// On-chip signal sources and period boundary seen by the block
// ------------------------------------------------------------
module wave_sources (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [9:0] level_i, // Wanted levels, pin select in bit 0
  input wire logic edge_i, // Request one period boundary pulse
  output logic [9:0] src_o, // Source levels, one cycle behind request
  output logic period_edge_o // One-cycle boundary pulse
);
  // Peripheral outputs are flops, so levels move only after an edge
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_o <= '0;
      period_edge_o <= 1'h0;
    end else begin
      src_o <= level_i;
      period_edge_o <= edge_i;
    end
  end
endmodule
`default_nettype wire

// [tb/waveform_gen_input_steering_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module waveform_gen_input_steering_sva
  import wavegen_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic clock_pick_o,
  input wire logic wave_output_a_o,
  input wire logic wave_output_b_o,
  input wire logic wave_output_c_o,
  input wire logic wave_output_d_o
);
  // ------------------------------------------------------------
  // Address of the read under way
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] rd_addr;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_addr <= '0;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rd_addr <= s_axi_araddr_i;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  property p_wr_resp;
    s_wr_take |-> ##[1:3] s_axi_bvalid_o;
  endproperty
  property p_aw_block;
    s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o;
  endproperty
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  property p_rd_resp;
    s_rd_take |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  property p_clk_read;
    s_axi_rvalid_o && rd_addr == ADDR_W'(ADDR_CLOCK_SOURCE_SELECT)
      |-> s_axi_rdata_o == {31'h0, clock_pick_o};
  endproperty
  property p_dat_read;
    s_axi_rvalid_o && rd_addr == ADDR_W'(ADDR_DATA_INPUT_SELECT) |-> s_axi_rdata_o[31:4] == 28'h0;
  endproperty
  property p_str_read;
    s_axi_rvalid_o && rd_addr == ADDR_W'(ADDR_OUTPUT_STEERING_CONTROL)
      |-> s_axi_rdata_o[31:8] == 24'h0;
  endproperty
  property p_bad_read;
    s_axi_rvalid_o && (rd_addr >> 4) != 0 |-> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == '0;
  endproperty
  property p_rst_out;
    $rose(reset_n_i) |-> !clock_pick_o && !wave_output_a_o && !wave_output_b_o
      && !wave_output_c_o && !wave_output_d_o;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  a_aw_block: assert property (p_aw_block) else $error("address ready not dropped");
  a_b_hold: assert property (p_b_hold) else $error("write answer not held");
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");
  a_clk_read: assert property (p_clk_read) else $error("clock select read wrong");
  a_dat_read: assert property (p_dat_read) else $error("data select upper bits set");
  a_str_read: assert property (p_str_read) else $error("steering upper bits set");
  a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");
  a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
endmodule
bind waveform_gen_input_steering waveform_gen_input_steering_sva #(.ADDR_W(ADDR_W))
  waveform_gen_input_steering_sva_i (.clk_sys_i, .reset_n_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .clock_pick_o, .wave_output_a_o,
  .wave_output_b_o, .wave_output_c_o, .wave_output_d_o);
`default_nettype wire

// [tb/tb_waveform_gen_input_steering.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_waveform_gen_input_steering;
  import wavegen_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clk_sys_i = 1'h0, reset_n_i = 1'h0, clk_en_i = 1'h1;
  logic [4:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0; // Reaches unmapped space
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h1;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h1; // Answers taken at once
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o, d;
  logic clock_pick_o, edge_req = 1'h0, period_edge;
  logic [3:0] wave; // Outputs D..A
  logic [9:0] levels = '0, src;
  logic [1:0] r;
  logic [7:0] st [4] = '{8'hA0, 8'h5F, 8'h3C, 8'hFF}; // Steering table
  logic [3:0] inv [4] = '{4'h0, 4'h1, 4'h6, 4'hF};
  logic dat [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
  int fail_count = 0, checks = 0;
  initial forever #50 clk_sys_i = ~clk_sys_i;
  wave_sources wave_sources_i (.clk_sys_i, .reset_n_i, .level_i(levels), .edge_i(edge_req),
    .src_o(src), .period_edge_o(period_edge));
  waveform_gen_input_steering #(.ADDR_W(5)) waveform_gen_input_steering_i (.clk_sys_i,
    .reset_n_i, .clk_en_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .pin_select_input_i(src[0]), .comparator_one_result_i(src[1]),
    .comparator_two_result_i(src[2]), .capture_compare_one_i(src[3]),
    .capture_compare_two_i(src[4]), .pulse_unit_five_i(src[5]), .pulse_unit_six_i(src[6]),
    .numeric_oscillator_one_i(src[7]), .logic_cell_one_i(src[8]),
    .logic_cell_two_i(src[9]), .period_edge_i(period_edge), .clock_pick_o,
    .wave_output_a_o(wave[0]), .wave_output_b_o(wave[1]), .wave_output_c_o(wave[2]),
    .wave_output_d_o(wave[3]));
  // ------------------------------------------------------------
  // Reporting and expectations
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk4(input logic [3:0] g, input logic [3:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t outputs %h expected %h", $time, g, e);
    end
  endtask
  // Source index for a code, -1 for a reserved code
  function automatic int src_idx(int c);
    if (c < 5) return c;
    if (c > 6 && c < 12) return c - 2;
    return -1;
  endfunction
  // Steered bits: data through polarity; others: force level
  function automatic logic [3:0] exp_out(logic [7:0] s, logic [3:0] p, logic v);
    return (s[3:0] & ({4{v}} ^ p)) | (~s[3:0] & s[7:4]);
  endfunction
  // ------------------------------------------------------------
  // Bus tasks: handshakes judged at the falling edge
  // ------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n = 0;
    logic ta, tw, tb = 1'h0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    while (!tb && n < 50) begin
      @(negedge clk_sys_i);
      ta = s_axi_awvalid_i && s_axi_awready_o;
      tw = s_axi_wvalid_i && s_axi_wready_o;
      tb = s_axi_bvalid_o;
      rs = s_axi_bresp_o;
      n++;
      @(posedge clk_sys_i);
      if (ta) s_axi_awvalid_i <= 1'h0;
      if (tw) s_axi_wvalid_i <= 1'h0;
    end
    if (!tb) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n = 0;
    logic ta, tr = 1'h0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    while (!tr && n < 50) begin
      @(negedge clk_sys_i);
      ta = s_axi_arvalid_i && s_axi_arready_o;
      tr = s_axi_rvalid_o;
      v = s_axi_rdata_o;
      rs = s_axi_rresp_o;
      n++;
      @(posedge clk_sys_i);
      if (ta) s_axi_arvalid_i <= 1'h0;
    end
    if (!tr) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic wput(input logic [4:0] a, input logic [31:0] v);
    logic [1:0] rs;
    wr(a, v, rs);
    chk32({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk32(v, e);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic pulse_edge;
    edge_req <= 1'h1;
    @(posedge clk_sys_i);
    edge_req <= 1'h0;
    ticks(3);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    ticks(6);
    reset_n_i <= 1'h1;
    @(posedge clk_sys_i);
    chk4(wave, 4'h0);
    for (int a = 0; a < 16; a += 4) begin
      rchk(5'(a), 32'h0);
    end
    wput(5'h00, 32'hFFFF_FFFF);
    rchk(5'h00, 32'h1);
    chk4({3'h0, clock_pick_o}, 4'h1);
    s_axi_wstrb_i <= 4'h0; // No lanes: field must stay
    wput(5'h00, 32'h0);
    s_axi_wstrb_i <= 4'hF;
    rchk(5'h00, 32'h1);
    wput(5'h04, 32'hFFFF_FFFF);
    rchk(5'h04, 32'hF);
    wr(5'h10, 32'h0, r);
    chk32({30'h0, r}, {30'h0, RESP_SLVERR});
    rchk(5'h00, 32'h1);
    rd(5'h10, d, r);
    chk32({30'h0, r}, {30'h0, RESP_SLVERR});
    // One-hot level on the expected source, all high for reserved codes
    for (int c = 0; c < 16; c++) begin
      levels <= (src_idx(c) < 0) ? 10'h3FF : 10'h1 << src_idx(c);
      wput(5'h04, 32'(c));
      ticks(2);
      rchk(5'h0C, {15'h0, src_idx(c) >= 0, 16'h0});
    end
    wput(5'h04, 32'h0);
    for (int k = 0; k < 4; k++) begin
      levels <= {9'h0, dat[k]};
      wput(5'h0C, {20'h0, inv[k], 8'h0});
      wput(5'h08, {24'hFF_FFFF, st[k]});
      ticks(2);
      chk4(wave, exp_out(st[k], inv[k], dat[k]));
      rchk(5'h08, {24'h0, st[k]});
    end
    wput(5'h0C, 32'h2);
    ticks(2);
    chk4(wave, 4'h0);
    // Synchronous steering: enables wait for the period boundary
    wput(5'h0C, 32'h1);
    wput(5'h08, 32'h0);
    levels <= 10'h1;
    pulse_edge();
    chk4(wave, 4'h0);
    wput(5'h08, 32'h0F);
    ticks(2);
    chk4(wave, 4'h0);
    pulse_edge();
    chk4(wave, 4'hF);
    clk_en_i <= 1'h0; // Frozen state ignores the source
    levels <= 10'h0;
    ticks(3);
    chk4(wave, 4'hF);
    give_verdict();
  end
endmodule
`default_nettype wire
